// ---- hw/dfws_pkg.sv ----
// Shared constants and types for the data flash word sequencer
package dfws_pkg;

  localparam int CLK_MHZ = 200;

  // Operation codes carried on the request
  localparam logic [2:0] OP_WORD_WRITE = 3'h1;
  localparam logic [2:0] OP_EVEN_WRITE = 3'h2;
  localparam logic [2:0] OP_PAIR_ERASE = 3'h3;
  localparam logic [2:0] OP_FULL_ERASE = 3'h4;
  localparam logic [2:0] OP_EVEN_READ  = 3'h5;

  // Error codes returned in the result word when carry is set
  localparam logic [15:0] ERR_TIMEOUT = 16'h0001;
  localparam logic [15:0] ERR_FAULT   = 16'h0002;
  localparam logic [15:0] ERR_ADDR    = 16'h0003;
  localparam logic [15:0] ERR_UNSUP   = 16'h0004;

  // Flash geometry: 128 words, two words per erase page
  localparam int          IDX_W        = 7;
  localparam int          WORDS        = 128;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam logic [15:0] FLASH_BASE   = 16'hc000;
  localparam logic [15:0] EVEN_MAX     = 16'h003f;
  localparam logic [8:0]  BASE_HI      = 9'h180;
  localparam logic [8:0]  FULL_COUNT   = 9'h080;
  localparam logic [8:0]  PAIR_COUNT   = 9'h002;
  localparam logic [8:0]  ONE_COUNT    = 9'h001;

  // Flash macro timing, in ns, and derived cycle counts (least times round up)
  localparam int T_PROG_NS  = 10000;
  localparam int T_ERASE_NS = 15000;
  localparam int T_TMO_NS   = 20480;
  localparam int PROG_CYC   = (T_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYC  = (T_ERASE_NS * CLK_MHZ + 999) / 1000;
  localparam int TMO_CYC    = (T_TMO_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W      = 13;

  typedef struct packed {
    logic [2:0]  op;
    logic [15:0] arg0;
    logic [15:0] arg1;
  } dfws_req_t;

  typedef struct packed {
    logic        carry;
    logic [15:0] word;
  } dfws_rsp_t;

endpackage

// ---- hw/dfws_word_mem.sv ----
// Word array standing in for the data flash cells, registered read
`timescale 1ns/1ps
`default_nettype none
module dfws_word_mem (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_we,
  input  wire logic [dfws_pkg::IDX_W-1:0] i_waddr,
  input  wire logic [15:0]               i_wdata,
  input  wire logic [dfws_pkg::IDX_W-1:0] i_raddr,
  output logic      [15:0]               o_rdata
);
  import dfws_pkg::*;

  logic [15:0] cells [WORDS];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      cells[i_waddr] <= i_wdata;
    end
    o_rdata <= cells[i_raddr];
  end
endmodule
`default_nettype wire

// ---- hw/dfws_sequencer.sv ----
// Data flash word sequencer: write, even write, pair erase, full erase, even read
`timescale 1ns/1ps
`default_nettype none
module dfws_sequencer (
  input  wire logic                i_core_clk,
  input  wire logic                i_arst_n,
  input  wire logic                i_start,
  input  wire dfws_pkg::dfws_req_t i_req,
  input  wire logic                i_flash_fault_flag,
  input  wire logic                i_flash_hold,
  output logic                     o_busy,
  output logic                     o_done,
  output dfws_pkg::dfws_rsp_t      o_rsp
);
  import dfws_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_CAP, ST_CHK_RD, ST_CHK, ST_WAIT, ST_FILL
  } dfws_state_t;

  // Translate an argument into a cell index for the given operation
  function automatic logic [IDX_W-1:0] cell_index(input logic [2:0] op,
                                                  input logic [15:0] arg);
    logic [15:0] phys;
    phys = FLASH_BASE | {arg[14:0], 1'b0};
    if (op == OP_WORD_WRITE || op == OP_PAIR_ERASE) begin
      phys = arg;
    end
    cell_index = phys[IDX_W-1:0];
  endfunction

  dfws_state_t      state;
  dfws_req_t        req;
  logic [CNT_W-1:0] wait_cnt;
  logic [CNT_W-1:0] tmo_cnt;
  logic [IDX_W-1:0] fill_idx;
  logic [8:0]       fill_left;
  logic [15:0]      fill_data;
  logic [15:0]      rdata;

  wire logic go = i_start && (state == ST_IDLE);
  wire logic op_known = (i_req.op == OP_WORD_WRITE) || (i_req.op == OP_EVEN_WRITE) ||
                        (i_req.op == OP_PAIR_ERASE) || (i_req.op == OP_FULL_ERASE) ||
                        (i_req.op == OP_EVEN_READ);
  wire logic in_region = (i_req.arg0[15:IDX_W] == BASE_HI);
  wire logic bad_addr  = ((i_req.op == OP_EVEN_WRITE) && (i_req.arg0 > EVEN_MAX)) ||
                         (((i_req.op == OP_WORD_WRITE) || (i_req.op == OP_PAIR_ERASE))
                          && !in_region);
  wire logic [IDX_W-1:0] req_idx = cell_index(i_req.op, i_req.arg0);
  wire logic [IDX_W-1:0] cur_idx = cell_index(req.op, req.arg0);
  wire logic timed_out = (tmo_cnt == CNT_W'(TMO_CYC));
  wire logic mem_we    = (state == ST_FILL);
  wire logic not_blank = (rdata != ERASED_WORD);
  wire logic [IDX_W-1:0] mem_raddr = (state == ST_IDLE) ? req_idx : cur_idx;

  assign o_busy = (state != ST_IDLE);

  dfws_word_mem u_mem (
    .i_core_clk (i_core_clk),
    .i_we       (mem_we),
    .i_waddr    (fill_idx),
    .i_wdata    (fill_data),
    .i_raddr    (mem_raddr),
    .o_rdata    (rdata)
  );

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state     <= ST_IDLE;
      req       <= '0;
      wait_cnt  <= '0;
      tmo_cnt   <= '0;
      fill_idx  <= '0;
      fill_left <= '0;
      fill_data <= '0;
      o_done    <= 1'b0;
      o_rsp     <= '0;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (go) begin
            req <= i_req;
            if (!op_known) begin
              o_done <= 1'b1;
              o_rsp  <= '{carry: 1'b1, word: ERR_UNSUP};
            end else if (bad_addr) begin
              o_done <= 1'b1;
              o_rsp  <= '{carry: 1'b1, word: ERR_ADDR};
            end else if (i_req.op == OP_EVEN_READ) begin
              state <= ST_RD;
            end else if (i_req.op == OP_FULL_ERASE) begin
              state     <= ST_WAIT;
              wait_cnt  <= CNT_W'(ERASE_CYC);
              tmo_cnt   <= '0;
              fill_idx  <= '0;
              fill_left <= FULL_COUNT;
              fill_data <= ERASED_WORD;
            end else if (i_req.op == OP_PAIR_ERASE) begin
              state     <= ST_WAIT;
              wait_cnt  <= CNT_W'(ERASE_CYC);
              tmo_cnt   <= '0;
              fill_idx  <= {req_idx[IDX_W-1:1], 1'b0};
              fill_left <= PAIR_COUNT;
              fill_data <= ERASED_WORD;
            end else begin
              state     <= ST_CHK_RD;
              fill_idx  <= req_idx;
              fill_left <= ONE_COUNT;
              fill_data <= i_req.arg1;
            end
          end
        end
        // Read address is presented while idle, so the cell is already in flight
        ST_RD: begin
          state <= ST_CAP;
        end
        ST_CAP: begin
          state  <= ST_IDLE;
          o_done <= 1'b1;
          o_rsp  <= '{carry: 1'b0, word: rdata};
        end
        ST_CHK_RD: begin
          state <= ST_CHK;
        end
        ST_CHK: begin
          if (not_blank) begin
            state  <= ST_IDLE;
            o_done <= 1'b1;
            o_rsp  <= '{carry: 1'b1, word: ERR_ADDR};
          end else begin
            state    <= ST_WAIT;
            wait_cnt <= CNT_W'(PROG_CYC);
            tmo_cnt  <= '0;
          end
        end
        // Macro may stall the program/erase; the watchdog counter never stalls
        ST_WAIT: begin
          tmo_cnt <= tmo_cnt + 1'b1;
          if (!i_flash_hold) begin
            wait_cnt <= wait_cnt - 1'b1;
          end
          if (timed_out) begin
            state  <= ST_IDLE;
            o_done <= 1'b1;
            o_rsp  <= '{carry: 1'b1, word: ERR_TIMEOUT};
          end else if (wait_cnt == '0) begin
            if (i_flash_fault_flag) begin
              state  <= ST_IDLE;
              o_done <= 1'b1;
              o_rsp  <= '{carry: 1'b1, word: ERR_FAULT};
            end else begin
              state <= ST_FILL;
            end
          end
        end
        ST_FILL: begin
          fill_idx  <= fill_idx + 1'b1;
          fill_left <= fill_left - 1'b1;
          if (fill_left == ONE_COUNT) begin
            state  <= ST_IDLE;
            o_done <= 1'b1;
            o_rsp  <= '{carry: 1'b0, word: req.arg0};
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Assertions
  sequence s_go_unsup;
    go && !op_known;
  endsequence

  sequence s_err_reply(logic [15:0] code);
    o_done && o_rsp.carry && (o_rsp.word == code);
  endsequence

  property p_unsup;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      s_go_unsup |=> s_err_reply(ERR_UNSUP);
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported op not answered with 4");

  property p_even_range;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      go && (i_req.op == OP_EVEN_WRITE) && (i_req.arg0 > EVEN_MAX)
      |=> s_err_reply(ERR_ADDR);
  endproperty
  a_even_range: assert property (p_even_range) else $error("even write range not enforced");

  property p_done_pulse;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      o_done && !go |=> !o_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  property p_busy_after_go;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      go && op_known && !bad_addr |=> o_busy && !o_done;
  endproperty
  a_busy_after_go: assert property (p_busy_after_go) else $error("busy not raised");

  property p_read_timing;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      go && (i_req.op == OP_EVEN_READ) |=> o_busy ##2 (o_done && !o_rsp.carry);
  endproperty
  a_read_timing: assert property (p_read_timing) else $error("even read reply wrong");

  property p_blank_check;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (state == ST_CHK) && not_blank |=> s_err_reply(ERR_ADDR);
  endproperty
  a_blank_check: assert property (p_blank_check) else $error("programmed cell overwritten");

  property p_code_range;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      o_done && o_rsp.carry |-> (o_rsp.word >= ERR_TIMEOUT) && (o_rsp.word <= ERR_UNSUP);
  endproperty
  a_code_range: assert property (p_code_range) else $error("error code out of range");

  property p_erase_data;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      mem_we && (req.op != OP_WORD_WRITE) && (req.op != OP_EVEN_WRITE)
      |-> (fill_data == ERASED_WORD);
  endproperty
  a_erase_data: assert property (p_erase_data) else $error("erase wrote non-blank");

  property p_pair_align;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      mem_we && (req.op == OP_PAIR_ERASE) && (fill_left == PAIR_COUNT)
      |-> !fill_idx[0] ##1 (mem_we && fill_idx[0]);
  endproperty
  a_pair_align: assert property (p_pair_align) else $error("pair erase not aligned");

  property p_timeout;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (state == ST_WAIT) && timed_out |=> s_err_reply(ERR_TIMEOUT);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not reported");
endmodule
`default_nettype wire

// ---- bench/dfws_core_model.sv ----
// Processor core model issuing flash commands and collecting results
`timescale 1ns/1ps
`default_nettype none
module dfws_core_model (
  input  wire logic                i_core_clk,
  input  wire logic                i_busy,
  input  wire logic                i_done,
  input  wire dfws_pkg::dfws_rsp_t i_rsp,
  output logic                     o_start,
  output dfws_pkg::dfws_req_t      o_req,
  output logic                     o_bad
);
  import dfws_pkg::*;
  logic watchdog_en;
  logic global_irq_enable;
  initial begin
    o_start = 1'b0;
    o_req = '0;
    o_bad = 1'b0;
    watchdog_en = 1'b1;
    global_irq_enable = 1'b1;
  end
  task automatic send(input logic [2:0] op, input logic [15:0] a0, input logic [15:0] a1);
    watchdog_en = 1'b0;
    global_irq_enable = 1'b0;
    @(posedge i_core_clk);
    #1;
    o_start = 1'b1;
    o_req = '{op, a0, a1};
    @(posedge i_core_clk);
    #1;
    o_start = 1'b0;
    // Arguments turn over once taken, so nothing may lean on them
    o_req = ~o_req;
  endtask
  task automatic collect(output dfws_rsp_t rsp, output int n);
    n = 0;
    o_bad = 1'b0;
    // A one-cycle answer is already up when send returns, so look before waiting
    while (i_done !== 1'b1 && n < 12000) begin
      if (i_busy !== 1'b1) o_bad = 1'b1;
      @(posedge i_core_clk);
      #1;
      n++;
    end
    rsp = i_rsp;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the data flash word sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dfws_pkg::*;
  typedef struct packed {
    logic [2:0]  op;
    logic [15:0] a0;
    logic [15:0] a1;
    dfws_rsp_t   exp;
  } dfws_row_t;
  logic      clk;
  logic      rst_n;
  logic      start;
  logic      fault;
  logic      hold;
  logic      busy;
  logic      done;
  logic      bad;
  dfws_req_t req;
  dfws_rsp_t rsp;
  dfws_rsp_t got;
  int        n;
  int        err_count;
  int        comparisons;
  // Full erase first: the array holds no known value after power-up
  dfws_row_t rows [17] = '{
    '{3'h4, 16'h0000, 16'h0000, {1'b0, 16'h0000}},
    '{3'h0, 16'hc000, 16'h0000, {1'b1, ERR_UNSUP}},
    '{3'h6, 16'hc000, 16'h0000, {1'b1, ERR_UNSUP}},
    '{3'h7, 16'hc000, 16'h0000, {1'b1, ERR_UNSUP}},
    '{3'h5, 16'h0000, 16'h0000, {1'b0, 16'hffff}},
    '{3'h1, 16'hc000, 16'h1234, {1'b0, 16'hc000}},
    '{3'h1, 16'hc000, 16'h5678, {1'b1, ERR_ADDR}},
    '{3'h5, 16'h0000, 16'h0000, {1'b0, 16'h1234}},
    '{3'h2, 16'h003f, 16'habcd, {1'b0, 16'h003f}},
    '{3'h2, 16'h0040, 16'h0001, {1'b1, ERR_ADDR}},
    '{3'h1, 16'hc080, 16'h0001, {1'b1, ERR_ADDR}},
    '{3'h1, 16'hc07f, 16'h5555, {1'b0, 16'hc07f}},
    '{3'h5, 16'h003f, 16'h0000, {1'b0, 16'habcd}},
    '{3'h3, 16'hc07f, 16'h0000, {1'b0, 16'hc07f}},
    '{3'h5, 16'h003f, 16'h0000, {1'b0, 16'hffff}},
    '{3'h1, 16'hc07f, 16'h7777, {1'b0, 16'hc07f}},
    '{3'h5, 16'h0000, 16'h0000, {1'b0, 16'h1234}}
  };

  dfws_sequencer dfws_sequencer_i (
    .i_core_clk         (clk),
    .i_arst_n           (rst_n),
    .i_start            (start),
    .i_req              (req),
    .i_flash_fault_flag (fault),
    .i_flash_hold       (hold),
    .o_busy             (busy),
    .o_done             (done),
    .o_rsp              (rsp)
  );
  dfws_core_model dfws_core_model_i (
    .i_core_clk (clk),
    .i_busy     (busy),
    .i_done     (done),
    .i_rsp      (rsp),
    .o_start    (start),
    .o_req      (req),
    .o_bad      (bad)
  );

  always #2.5 clk = ~clk;

  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp_rsp(input string what, input dfws_rsp_t exp, input dfws_rsp_t seen);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", what, exp, seen);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic seen);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %b got %b", what, exp, seen);
    end
  endtask
  task automatic finish_cmd(input dfws_rsp_t exp);
    dfws_core_model_i.collect(got, n);
    cmp_bit("answered", 1'b1, n < 12000);
    if (n >= 12000) wrap_up();
    cmp_bit("busy_gap", 1'b0, bad);
    cmp_rsp("rsp", exp, got);
  endtask
  task automatic idle_check;
    cmp_bit("busy_rst", 1'b0, busy);
    cmp_bit("done_rst", 1'b0, done);
    cmp_rsp("rsp_rst", '0, rsp);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    fault = 1'b0;
    hold = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    #1;
    idle_check();
    rst_n = 1'b1;
    foreach (rows[i]) begin
      dfws_core_model_i.send(rows[i].op, rows[i].a0, rows[i].a1);
      finish_cmd(rows[i].exp);
    end
    // Second start lands while busy and must vanish without a trace
    dfws_core_model_i.send(OP_WORD_WRITE, 16'hc001, 16'h2222);
    dfws_core_model_i.send(3'h0, 16'h0000, 16'h0000);
    finish_cmd({1'b0, 16'hc001});
    dfws_core_model_i.send(OP_EVEN_READ, 16'h0040, 16'h0000);
    finish_cmd({1'b0, 16'h1234});
    fault = 1'b1;
    dfws_core_model_i.send(OP_FULL_ERASE, 16'h0000, 16'h0000);
    finish_cmd({1'b1, ERR_FAULT});
    fault = 1'b0;
    hold = 1'b1;
    dfws_core_model_i.send(OP_WORD_WRITE, 16'hc003, 16'h0003);
    finish_cmd({1'b1, ERR_TIMEOUT});
    hold = 1'b0;
    dfws_core_model_i.send(OP_WORD_WRITE, 16'hc004, 16'h0004);
    repeat (7) @(posedge clk);
    #1;
    rst_n = 1'b0;
    #1;
    idle_check();
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    // The write cut by reset must not have reached its cell
    dfws_core_model_i.send(OP_EVEN_READ, 16'h0002, 16'h0000);
    finish_cmd({1'b0, 16'hffff});
    wrap_up();
  end
endmodule
`default_nettype wire
